// ---- core/act_pkg.sv ----
// constants, register map and carrier types of the converter trim register bank
// assumes one 100 MHz system clock and an AXI4-Lite master with 32-bit data
package act_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0]  IDX_SPARE_FOR_SECOND_TIMING = 10'h088;
    localparam logic [9:0]  IDX_SECOND_CORE_DUAL_TIMING = 10'h089;
    localparam logic [9:0]  IDX_FIRST_CORE_IN_ONE_OFS   = 10'h08A;
    localparam logic [9:0]  IDX_FIRST_CORE_IN_TWO_OFS   = 10'h08C;
    localparam logic [9:0]  IDX_SPARE_CORE_IN_ONE_OFS   = 10'h08E;
    localparam logic [9:0]  IDX_TRIM_STATUS             = 10'h0C0;

    // ------------------------------------------------------------------
    // field layout and values after reset
    // ------------------------------------------------------------------
    localparam int          TIMING_MSB      = 7;
    localparam int          OFS_MSB         = 11;
    localparam int          RSVD_LSB        = 12;
    localparam logic [3:0]  RSVD_RESET      = 4'h0;
    localparam int          ST_FG_RUNNING   = 0;
    localparam int          ST_BG_EN        = 1;
    localparam int          ST_BGOS_EN      = 2;
    localparam int          ST_OS_EN        = 3;
    localparam int          ST_FOREGROUND_DONE_FLAG      = 4;
    localparam int          ST_HALTED       = 5;
    localparam int          ST_READ_SAFE    = 6;
    localparam int          ST_WR_LOCKED    = 7;
    localparam int          ST_WR_VIOLATION = 8;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  spare_for_second_timing_trim;
        logic [7:0]  second_core_dual_timing_trim;
        logic [15:0] first_core_input_one_offset_trim;
        logic [15:0] first_core_input_two_offset_trim;
        logic [15:0] spare_core_input_one_offset_trim;
    } act_trims_t;

    typedef struct packed {
        logic fg_running;
        logic bg_enable;
        logic bg_offset_enable;
        logic offset_enable;
        logic foreground_done_flag;
        logic halted;
    } act_cal_state_t;

endpackage

// ---- core/act_trim_regs.sv ----
// trim register bank: timing and offset trims behind an AXI4-Lite slave
// assumes factory trims and calibration state arrive on the system clock
//
// Function
// - each timing trim is an 8-bit read/write value moving its core's sampling instant
// - each timing trim drives only its own core, channel mode and phase
// - after reset trims read factory values with offset bits 15:12 cleared; written values then take effect
// - spare-for-second timing trim sits at its own index 0x088
// - second-core dual-mode timing trim sits at index 0x089
// - first core, first input offset: 12-bit unsigned, upper four bits reserved
// - first core, second input offset has its own 12-bit register at 0x08C
// - spare core, first input offset: 12-bit field under four reserved bits
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module act_trim_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_clk_en,
    input  wire logic [ADDR_W-1:0]       i_awaddr,
    input  wire logic                    i_awvalid,
    output logic                         o_awready,
    input  wire logic [31:0]             i_wdata,
    input  wire logic [3:0]              i_wstrb,
    input  wire logic                    i_wvalid,
    output logic                         o_wready,
    output logic [1:0]                   o_bresp,
    output logic                         o_bvalid,
    input  wire logic                    i_bready,
    input  wire logic [ADDR_W-1:0]       i_araddr,
    input  wire logic                    i_arvalid,
    output logic                         o_arready,
    output logic [31:0]                  o_rdata,
    output logic [1:0]                   o_rresp,
    output logic                         o_rvalid,
    input  wire logic                    i_rready,
    input  wire act_pkg::act_trims_t     i_factory_trims,
    input  wire act_pkg::act_cal_state_t i_cal_state,
    input  wire logic                    i_dual_mode,
    input  wire logic                    i_spare_for_second,
    input  wire logic                    i_first_on_second_input,
    input  wire logic                    i_spare_on_first_input,
    output logic [7:0]                   o_second_core_timing,
    output logic                         o_second_core_timing_valid,
    output logic [7:0]                   o_spare_core_timing,
    output logic                         o_spare_core_timing_valid,
    output logic [11:0]                  o_first_core_offset,
    output logic [11:0]                  o_spare_core_offset,
    output logic                         o_spare_core_offset_valid
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                loaded;
        act_pkg::act_trims_t trims;
        logic                wr_violation;
        logic                awready;
        logic                wready;
        logic                aw_held;
        logic [9:0]          aw_idx;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [7:0]          second_timing;
        logic                second_timing_valid;
        logic [7:0]          spare_timing;
        logic                spare_timing_valid;
        logic [11:0]         first_offset;
        logic [11:0]         spare_offset;
        logic                spare_offset_valid;
    } act_state_t;

    act_state_t st_reg;
    act_state_t st_next;
    logic       wr_fire;
    logic       wr_locked;
    logic       rd_safe;
    logic [8:0] status_word;

    // ------------------------------------------------------------------
    // calibration-engine view
    // ------------------------------------------------------------------
    // the bank cannot stall the engine, so unsafe host writes are only flagged
    assign wr_locked = i_cal_state.fg_running
                     | (i_cal_state.bg_enable & i_cal_state.bg_offset_enable);

    always_comb begin
        rd_safe = 1'b1;
        if (i_cal_state.offset_enable && !i_cal_state.bg_offset_enable) begin
            rd_safe = i_cal_state.foreground_done_flag;
        end else if (i_cal_state.bg_enable && i_cal_state.bg_offset_enable) begin
            rd_safe = i_cal_state.halted;
        end
    end

    always_comb begin
        status_word                           = '0;
        status_word[act_pkg::ST_FG_RUNNING]   = i_cal_state.fg_running;
        status_word[act_pkg::ST_BG_EN]        = i_cal_state.bg_enable;
        status_word[act_pkg::ST_BGOS_EN]      = i_cal_state.bg_offset_enable;
        status_word[act_pkg::ST_OS_EN]        = i_cal_state.offset_enable;
        status_word[act_pkg::ST_FOREGROUND_DONE_FLAG]      = i_cal_state.foreground_done_flag;
        status_word[act_pkg::ST_HALTED]       = i_cal_state.halted;
        status_word[act_pkg::ST_READ_SAFE]    = rd_safe;
        status_word[act_pkg::ST_WR_LOCKED]    = wr_locked;
        status_word[act_pkg::ST_WR_VIOLATION] = st_reg.wr_violation;
    end

    assign wr_fire = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;

    // ------------------------------------------------------------------
    // byte-lane merge of a 16-bit register
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [9:0]  ridx;
        logic [31:0] rword;
        logic [1:0]  rresp;
        ridx    = '0;
        rword   = '0;
        rresp   = act_pkg::RESP_OKAY;
        st_next = st_reg;

        if (!st_reg.loaded) begin
            // factory values land once, on the first enabled edge after release
            st_next.trims = i_factory_trims;
            st_next.trims.first_core_input_one_offset_trim[15:12] = act_pkg::RSVD_RESET;
            st_next.trims.first_core_input_two_offset_trim[15:12] = act_pkg::RSVD_RESET;
            st_next.trims.spare_core_input_one_offset_trim[15:12] = act_pkg::RSVD_RESET;
            st_next.loaded  = 1'b1;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
            st_next.arready = 1'b1;
        end else begin
            // write address and data, taken in either order
            if (i_awvalid && st_reg.awready) begin
                st_next.aw_held = 1'b1;
                st_next.aw_idx  = i_awaddr[11:2];
                st_next.awready = 1'b0;
            end
            if (i_wvalid && st_reg.wready) begin
                st_next.w_held = 1'b1;
                st_next.w_data = i_wdata;
                st_next.w_strb = i_wstrb;
                st_next.wready = 1'b0;
            end

            // clear first; wr_fire needs bvalid low, so no write response lands in the same cycle as this clear
            if (st_reg.bvalid && i_bready) begin
                st_next.bvalid  = 1'b0;
                st_next.awready = 1'b1;
                st_next.wready  = 1'b1;
            end

            if (wr_fire) begin
                st_next.aw_held = 1'b0;
                st_next.w_held  = 1'b0;
                st_next.bvalid  = 1'b1;
                st_next.bresp   = act_pkg::RESP_OKAY;
                if (st_reg.aw_idx == act_pkg::IDX_SPARE_FOR_SECOND_TIMING) begin
                    if (st_reg.w_strb[0]) begin
                        st_next.trims.spare_for_second_timing_trim = st_reg.w_data[7:0];
                    end
                end else if (st_reg.aw_idx == act_pkg::IDX_SECOND_CORE_DUAL_TIMING) begin
                    if (st_reg.w_strb[0]) begin
                        st_next.trims.second_core_dual_timing_trim = st_reg.w_data[7:0];
                    end
                end else if (st_reg.aw_idx == act_pkg::IDX_FIRST_CORE_IN_ONE_OFS) begin
                    st_next.trims.first_core_input_one_offset_trim =
                        merge16(st_reg.trims.first_core_input_one_offset_trim,
                                st_reg.w_data, st_reg.w_strb);
                    st_next.wr_violation = st_reg.wr_violation | wr_locked;
                end else if (st_reg.aw_idx == act_pkg::IDX_FIRST_CORE_IN_TWO_OFS) begin
                    st_next.trims.first_core_input_two_offset_trim =
                        merge16(st_reg.trims.first_core_input_two_offset_trim,
                                st_reg.w_data, st_reg.w_strb);
                    st_next.wr_violation = st_reg.wr_violation | wr_locked;
                end else if (st_reg.aw_idx == act_pkg::IDX_SPARE_CORE_IN_ONE_OFS) begin
                    st_next.trims.spare_core_input_one_offset_trim =
                        merge16(st_reg.trims.spare_core_input_one_offset_trim,
                                st_reg.w_data, st_reg.w_strb);
                    st_next.wr_violation = st_reg.wr_violation | wr_locked;
                end else if (st_reg.aw_idx == act_pkg::IDX_TRIM_STATUS) begin
                    if (st_reg.w_strb[1] && st_reg.w_data[act_pkg::ST_WR_VIOLATION]) begin
                        st_next.wr_violation = 1'b0;
                    end
                end else begin
                    st_next.bresp = act_pkg::RESP_SLVERR;
                end
            end

            // read channel
            if (st_reg.rvalid && i_rready) begin
                st_next.rvalid  = 1'b0;
                st_next.arready = 1'b1;
            end
            if (i_arvalid && st_reg.arready) begin
                ridx = i_araddr[11:2];
                if (ridx == act_pkg::IDX_SPARE_FOR_SECOND_TIMING) begin
                    rword[7:0] = st_reg.trims.spare_for_second_timing_trim;
                end else if (ridx == act_pkg::IDX_SECOND_CORE_DUAL_TIMING) begin
                    rword[7:0] = st_reg.trims.second_core_dual_timing_trim;
                end else if (ridx == act_pkg::IDX_FIRST_CORE_IN_ONE_OFS) begin
                    rword[15:0] = st_reg.trims.first_core_input_one_offset_trim;
                end else if (ridx == act_pkg::IDX_FIRST_CORE_IN_TWO_OFS) begin
                    rword[15:0] = st_reg.trims.first_core_input_two_offset_trim;
                end else if (ridx == act_pkg::IDX_SPARE_CORE_IN_ONE_OFS) begin
                    rword[15:0] = st_reg.trims.spare_core_input_one_offset_trim;
                end else if (ridx == act_pkg::IDX_TRIM_STATUS) begin
                    rword[8:0] = status_word;
                end else begin
                    rresp = act_pkg::RESP_SLVERR;
                end
                st_next.arready = 1'b0;
                st_next.rvalid  = 1'b1;
                st_next.rdata   = rword;
                st_next.rresp   = rresp;
            end
        end

        // applied trims: reserved bits never reach a core
        st_next.second_timing_valid = i_dual_mode & ~i_spare_for_second;
        st_next.second_timing       = st_next.second_timing_valid
                                    ? st_reg.trims.second_core_dual_timing_trim : 8'h00;
        st_next.spare_timing_valid  = i_dual_mode & i_spare_for_second;
        st_next.spare_timing        = st_next.spare_timing_valid
                                    ? st_reg.trims.spare_for_second_timing_trim : 8'h00;
        st_next.first_offset        = i_first_on_second_input
                                    ? st_reg.trims.first_core_input_two_offset_trim[11:0]
                                    : st_reg.trims.first_core_input_one_offset_trim[11:0];
        st_next.spare_offset_valid  = i_spare_on_first_input;
        st_next.spare_offset        = i_spare_on_first_input
                                    ? st_reg.trims.spare_core_input_one_offset_trim[11:0]
                                    : 12'h000;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_awready                  = st_reg.awready;
    assign o_wready                   = st_reg.wready;
    assign o_bvalid                   = st_reg.bvalid;
    assign o_bresp                    = st_reg.bresp;
    assign o_arready                  = st_reg.arready;
    assign o_rvalid                   = st_reg.rvalid;
    assign o_rdata                    = st_reg.rdata;
    assign o_rresp                    = st_reg.rresp;
    assign o_second_core_timing       = st_reg.second_timing;
    assign o_second_core_timing_valid = st_reg.second_timing_valid;
    assign o_spare_core_timing        = st_reg.spare_timing;
    assign o_spare_core_timing_valid  = st_reg.spare_timing_valid;
    assign o_first_core_offset        = st_reg.first_offset;
    assign o_spare_core_offset        = st_reg.spare_offset;
    assign o_spare_core_offset_valid  = st_reg.spare_offset_valid;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    factory_load_a: assert property ($rose(st_reg.loaded) |->
        st_reg.trims.first_core_input_one_offset_trim[11:0]
        == $past(i_factory_trims.first_core_input_one_offset_trim[11:0])
        && st_reg.trims.first_core_input_one_offset_trim[15:12] == 4'h0)
        else $error("factory trim not loaded after reset");

    spare_timing_wr_a: assert property (wr_fire && i_clk_en && st_reg.w_strb[0]
        && st_reg.aw_idx == act_pkg::IDX_SPARE_FOR_SECOND_TIMING |=>
        st_reg.trims.spare_for_second_timing_trim == $past(st_reg.w_data[7:0]) && st_reg.bvalid)
        else $error("spare timing trim write lost");

    second_timing_wr_a: assert property (wr_fire && i_clk_en && st_reg.w_strb[0]
        && st_reg.aw_idx == act_pkg::IDX_SECOND_CORE_DUAL_TIMING |=>
        st_reg.trims.second_core_dual_timing_trim == $past(st_reg.w_data[7:0]))
        else $error("second core timing trim write lost");

    timing_apply_a: assert property (i_clk_en && i_dual_mode && !i_spare_for_second |=>
        o_second_core_timing == $past(st_reg.trims.second_core_dual_timing_trim)
        && o_second_core_timing_valid && !o_spare_core_timing_valid)
        else $error("timing trim applied to wrong core");

    read_width_a: assert property ($rose(o_rvalid) |-> o_rdata[31:16] == 16'h0000)
        else $error("read data above sixteen bits not zero");

    first_ofs_sel_a: assert property (i_clk_en && i_first_on_second_input && st_reg.loaded |=>
        o_first_core_offset == $past(st_reg.trims.first_core_input_two_offset_trim[11:0]))
        else $error("first core offset not from second input trim");

    spare_ofs_a: assert property (i_clk_en && i_spare_on_first_input |=>
        o_spare_core_offset == $past(st_reg.trims.spare_core_input_one_offset_trim[11:0]))
        else $error("spare core offset wrong");

    rsvd_store_a: assert property (wr_fire && i_clk_en && st_reg.w_strb[1]
        && st_reg.aw_idx == act_pkg::IDX_FIRST_CORE_IN_ONE_OFS |=>
        st_reg.trims.first_core_input_one_offset_trim[15:12] == $past(st_reg.w_data[15:12]))
        else $error("reserved offset bits not stored");

    locked_write_a: assert property (wr_fire && i_clk_en && wr_locked
        && st_reg.aw_idx == act_pkg::IDX_FIRST_CORE_IN_TWO_OFS |=> st_reg.wr_violation)
        else $error("locked offset write not flagged");

    write_seen_c: cover property (wr_fire && i_clk_en ##1 o_bvalid);
    read_seen_c: cover property (i_arvalid && o_arready ##1 o_rvalid);
    spare_sub_c: cover property (o_spare_core_timing_valid ##1 o_second_core_timing_valid);
    violation_c: cover property ($rose(st_reg.wr_violation));

endmodule

// ---- sim/act_trim_regs_tb.sv ----
// bench for the trim register bank: AXI4-Lite accesses with expected values
// assumes factory trims are sampled at the first enabled edge after reset
`timescale 1ns/10ps

module act_trim_regs_tb;
    logic                    i_clk_sys = 1'b0;
    logic                    i_rst_n = 1'b0;
    logic                    i_clk_en = 1'b1;
    logic [11:0]             i_awaddr = 12'h000, i_araddr = 12'h000;
    logic                    i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic                    i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0]             i_wdata = 32'h0, o_rdata, rd;
    logic [3:0]              i_wstrb = 4'h0;
    logic                    o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]              o_bresp, o_rresp, resp;
    act_pkg::act_trims_t     i_factory_trims = '{8'hA5, 8'h3C, 16'hF123, 16'h0456, 16'h0789};
    act_pkg::act_cal_state_t i_cal_state = 6'h00;
    logic                    i_dual_mode = 1'b0, i_spare_for_second = 1'b0;
    logic                    i_first_on_second_input = 1'b0, i_spare_on_first_input = 1'b0;
    logic [7:0]              o_second_core_timing, o_spare_core_timing;
    logic                    o_second_core_timing_valid, o_spare_core_timing_valid;
    logic [11:0]             o_first_core_offset, o_spare_core_offset;
    logic                    o_spare_core_offset_valid;
    int                      fail_count = 0, n_tests = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    act_trim_regs DUT (.i_clk_sys, .i_rst_n, .i_clk_en, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_factory_trims,
        .i_cal_state, .i_dual_mode, .i_spare_for_second, .i_first_on_second_input,
        .i_spare_on_first_input, .o_second_core_timing, .o_second_core_timing_valid,
        .o_spare_core_timing, .o_spare_core_timing_valid, .o_first_core_offset,
        .o_spare_core_offset, .o_spare_core_offset_valid);

    // --------------------------------------------------------------
    // bus tasks
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // leading edge keeps a lowered ready from being raised in the same step
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er = act_pkg::RESP_OKAY);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge i_clk_sys);
        i_awaddr <= {idx, 2'b00};
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_clk_sys);
            if (!aw_ok && o_awready) begin
                aw_ok = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (!w_ok && o_wready) begin
                w_ok = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clk_sys); while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        chk("write response", {30'h0, o_bresp}, {30'h0, er});
    endtask

    task automatic rc(input string what, input logic [9:0] idx, input logic [31:0] exp,
                      input logic [1:0] er = act_pkg::RESP_OKAY);
        @(posedge i_clk_sys);
        i_araddr <= {idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_clk_sys); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_clk_sys); while (o_rvalid !== 1'b1);
        rd = o_rdata;
        i_rready <= 1'b0;
        chk({what, " response"}, {30'h0, o_rresp}, {30'h0, er});
        chk(what, rd, exp);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rc("spare timing", act_pkg::IDX_SPARE_FOR_SECOND_TIMING, 32'hA5);
        rc("second timing", act_pkg::IDX_SECOND_CORE_DUAL_TIMING, 32'h3C);
        rc("first in one", act_pkg::IDX_FIRST_CORE_IN_ONE_OFS, 32'h0123);
        rc("first in two", act_pkg::IDX_FIRST_CORE_IN_TWO_OFS, 32'h0456);
        rc("spare in one", act_pkg::IDX_SPARE_CORE_IN_ONE_OFS, 32'h0789);
        $display("test reset values done");
        i_dual_mode <= 1'b1;
        wr(act_pkg::IDX_SECOND_CORE_DUAL_TIMING, 32'hFFFF_FF5A, 4'hF);
        wr(act_pkg::IDX_SPARE_FOR_SECOND_TIMING, 32'h0000_00C3, 4'h1);
        rc("second timing rb", act_pkg::IDX_SECOND_CORE_DUAL_TIMING, 32'h5A);
        repeat (2) @(posedge i_clk_sys);
        chk("second out", {23'h0, o_second_core_timing_valid, o_second_core_timing},
            32'h15A);
        chk("spare out", {23'h0, o_spare_core_timing_valid, o_spare_core_timing},
            32'h000);
        i_spare_for_second <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk("second off", {23'h0, o_second_core_timing_valid, o_second_core_timing},
            32'h000);
        chk("spare on", {23'h0, o_spare_core_timing_valid, o_spare_core_timing},
            32'h1C3);
        $display("test timing trims done");
        wr(act_pkg::IDX_FIRST_CORE_IN_ONE_OFS, 32'h0000_9ABC, 4'h3);
        wr(act_pkg::IDX_FIRST_CORE_IN_TWO_OFS, 32'h0000_5DEF, 4'h3);
        wr(act_pkg::IDX_SPARE_CORE_IN_ONE_OFS, 32'h0000_F321, 4'h3);
        rc("reserved rb", act_pkg::IDX_FIRST_CORE_IN_ONE_OFS, 32'h9ABC);
        i_spare_on_first_input <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk("first offset", {20'h0, o_first_core_offset}, 32'hABC);
        chk("spare offset", {19'h0, o_spare_core_offset_valid, o_spare_core_offset},
            32'h1321);
        i_first_on_second_input <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk("first offset two", {20'h0, o_first_core_offset}, 32'hDEF);
        // unmapped odd indices must not alias onto the two-byte trims
        rc("unmapped", 10'h08B, 32'h0, act_pkg::RESP_SLVERR);
        wr(10'h08D, 32'h0000_FFFF, 4'h3, act_pkg::RESP_SLVERR);
        rc("no alias", act_pkg::IDX_FIRST_CORE_IN_TWO_OFS, 32'h5DEF);
        $display("test offset trims done");
        i_cal_state <= 6'b100000;
        wr(act_pkg::IDX_FIRST_CORE_IN_ONE_OFS, 32'h0000_0111, 4'h3);
        rc("locked store", act_pkg::IDX_FIRST_CORE_IN_ONE_OFS, 32'h0111);
        rc("violation", act_pkg::IDX_TRIM_STATUS, 32'h1C1);
        // sticky flag clears only by a one in bit 8 through lane 1
        wr(act_pkg::IDX_TRIM_STATUS, 32'h0000_0100, 4'h2);
        i_cal_state <= 6'b011001;
        rc("bg halted", act_pkg::IDX_TRIM_STATUS, 32'h0E6);
        wr(act_pkg::IDX_FIRST_CORE_IN_TWO_OFS, 32'h0000_0222, 4'h3);
        rc("bg violation", act_pkg::IDX_TRIM_STATUS, 32'h1E6);
        i_cal_state <= 6'b011000;
        rc("bg running", act_pkg::IDX_TRIM_STATUS, 32'h186);
        i_cal_state <= 6'b000110;
        rc("foreground_done_flag", act_pkg::IDX_TRIM_STATUS, 32'h158);
        i_cal_state <= 6'b000100;
        rc("fg pending", act_pkg::IDX_TRIM_STATUS, 32'h108);
        $display("test calibration gating done");
        // enable low must hold the applied trims although the mode drops
        i_clk_en <= 1'b0;
        i_dual_mode <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk("frozen", {23'h0, o_spare_core_timing_valid, o_spare_core_timing},
            32'h1C3);
        i_clk_en <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        chk("released", {23'h0, o_spare_core_timing_valid, o_spare_core_timing},
            32'h000);
        $display("test clock enable done");
        tally_and_finish;
    end

    // whole run is about a hundred cycles; this margin only catches a hang
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        fail_count++;
        tally_and_finish;
    end
endmodule
